// *** pupo_pkg.sv ***
package pupo_pkg;
   // Power-up clearing time in nanoseconds and its cycle count at 10 MHz.
   localparam int unsigned PUPO_CLK_PERIOD_NS = 100;
   localparam int unsigned PUPO_PWRUP_NS = 10000;
   localparam int unsigned PUPO_PWRUP_CYC = PUPO_PWRUP_NS / PUPO_CLK_PERIOD_NS;
   // Default cell counts.
   localparam int unsigned PUPO_NUM_OUT = 8;
   localparam int unsigned PUPO_NUM_BUR = 8;
   // Clearing value of every macrocell register.
   localparam logic PUPO_FF_RST = 1'b0;
   // Sequencer states, Gray coded.
   typedef enum logic [1:0] {
      PUPO_ST_CLEAR = 2'b00,
      PUPO_ST_RUN = 2'b01,
      PUPO_ST_TEST = 2'b11
   } pupo_state_t;
endpackage : pupo_pkg

// *** pupo_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
// One macrocell: register, combinatorial path, polarity and output enable.
module pupo_cell (
   // Clock and control.
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic clear_i,
   input wire logic preload_i,
   input wire logic observe_i,
   // Configuration.
   input wire logic comb_mode_i,
   input wire logic invert_i,
   // Logic inputs.
   input wire logic func_d_i,
   input wire logic func_oe_i,
   input wire logic async_rst_i,
   input wire logic async_set_i,
   input wire logic pin_d_i,
   // Results.
   output logic reg_q_o,
   output logic pin_o,
   output logic pin_oe_o
);
   import pupo_pkg::*;
   logic ff_q;
   logic ff_d;
   logic test;
   logic sum;
   // Next register value; clearing wins, then reset and preset, then preload.
   always_comb begin
      test = preload_i | observe_i;
      ff_d = ff_q;
      if (clear_i) begin
         ff_d = PUPO_FF_RST;
      end else if (async_rst_i) begin
         ff_d = 1'b0;
      end else if (async_set_i) begin
         ff_d = 1'b1;
      end else if (preload_i) begin
         ff_d = pin_d_i;
      end else if (!observe_i) begin
         ff_d = func_d_i;
      end
      // Under test, product terms are forced to zero and the cell is registered.
      sum = test ? 1'b0 : func_d_i;
      pin_o = ((comb_mode_i && !test) ? sum : ff_q) ^ invert_i;
      pin_oe_o = observe_i | (func_oe_i & !preload_i);
   end
   // Register update, frozen while the clock enable is low.
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         ff_q <= ff_d;
      end
   end
   assign reg_q_o = ff_q;
endmodule : pupo_cell
`default_nettype wire

// *** pupo_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Power-up clearing, preload and observe control around a set of macrocells.
module pupo_top #(
   parameter int unsigned NUM_OUT = pupo_pkg::PUPO_NUM_OUT,
   parameter int unsigned NUM_BUR = pupo_pkg::PUPO_NUM_BUR,
   parameter int unsigned PWRUP_CYC = pupo_pkg::PUPO_PWRUP_CYC
) (
   // Clock, enable and reset.
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic sys_rst_i,
   // Test-mode controls.
   input wire logic preload_i,
   input wire logic observe_i,
   input wire logic bur_sel_i,
   // Configuration per output cell.
   input wire logic [NUM_OUT-1:0] comb_mode_i,
   input wire logic [NUM_OUT-1:0] invert_i,
   // Functional logic inputs per cell, output cells then buried cells; output enables for output cells only.
   input wire logic [NUM_OUT+NUM_BUR-1:0] func_d_i,
   input wire logic [NUM_OUT-1:0] func_oe_i,
   input wire logic [NUM_OUT+NUM_BUR-1:0] async_rst_i,
   input wire logic [NUM_OUT+NUM_BUR-1:0] async_set_i,
   // I/O pins.
   input wire logic [NUM_OUT-1:0] pin_i,
   output logic [NUM_OUT-1:0] pin_o,
   output logic [NUM_OUT-1:0] pin_oe_o,
   // Status.
   output logic ready_o
);
   import pupo_pkg::*;
   localparam int unsigned NC = NUM_OUT + NUM_BUR;
   localparam int unsigned CW = $clog2(PWRUP_CYC + 1);

   initial begin
      if (NUM_OUT < 1 || NUM_BUR > NUM_OUT || PWRUP_CYC < 1) begin
         $error("pupo_top: unsupported parameters");
      end
   end

   pupo_state_t st_q, st_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic ready_q, ready_d;
   logic [NUM_OUT-1:0] po_q, po_d, oe_q, oe_d;
   logic [NC-1:0] rq;
   logic [NC-1:0] cp;
   logic [NC-1:0] coe;
   logic [NC-1:0] cpin;
   logic clearing;
   logic pre_g;
   logic obs_g;

   // Clearing runs during reset and the power-up window; test only afterwards.
   always_comb begin
      clearing = (st_q == PUPO_ST_CLEAR) | sys_rst_i;
      pre_g = preload_i & !clearing;
      obs_g = observe_i & !preload_i & !clearing;
   end

   // Sequencer next state.
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ready_d = ready_q;
      if (sys_rst_i) begin
         st_d = PUPO_ST_CLEAR;
         cnt_d = '0;
         ready_d = 1'b0;
      end else begin
         case (st_q)
            PUPO_ST_CLEAR: begin
               if (cnt_q >= CW'(PWRUP_CYC - 1)) begin
                  st_d = PUPO_ST_RUN;
                  ready_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + CW'(1);
               end
            end
            PUPO_ST_RUN: begin
               if (preload_i | observe_i) begin
                  st_d = PUPO_ST_TEST;
               end
            end
            PUPO_ST_TEST: begin
               if (!(preload_i | observe_i)) begin
                  st_d = PUPO_ST_RUN;
               end
            end
            default: begin
               st_d = PUPO_ST_CLEAR;
            end
         endcase
      end
   end

   // Sequencer registers.
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
      end
   end

   // Preload pins map to output cells directly and to buried cells when selected.
   genvar g;
   generate
      for (g = 0; g < NC; g++) begin : g_cell
         if (g < NUM_OUT) begin : g_out
            assign cpin[g] = pin_i[g];
         end else begin : g_bur
            assign cpin[g] = pin_i[g-NUM_OUT];
         end
         pupo_cell u_cell (
            .clk_i(clk_i),
            .ce_i(ce_i),
            .clear_i(clearing),
            .preload_i(g < NUM_OUT ? (pre_g & !bur_sel_i) : (pre_g & bur_sel_i)),
            .observe_i(obs_g),
            .comb_mode_i(g < NUM_OUT ? comb_mode_i[g % NUM_OUT] : 1'b0),
            .invert_i(g < NUM_OUT ? invert_i[g % NUM_OUT] : 1'b0),
            .func_d_i(func_d_i[g]),
            .func_oe_i(g < NUM_OUT ? func_oe_i[g % NUM_OUT] : 1'b0),
            .async_rst_i(async_rst_i[g] & !clearing),
            .async_set_i(async_set_i[g] & !clearing),
            .pin_d_i(cpin[g]),
            .reg_q_o(rq[g]),
            .pin_o(cp[g]),
            .pin_oe_o(coe[g])
         );
      end
   endgenerate

   // Pin drivers; observe with buried select shows buried register contents.
   always_comb begin
      po_d = cp[NUM_OUT-1:0];
      oe_d = coe[NUM_OUT-1:0];
      if (clearing) begin
         oe_d = '0;
      end else if (pre_g) begin
         // Release every pin while loading, so preload data after the first load edge never reads our own drive.
         oe_d = '0;
      end else if (obs_g && bur_sel_i) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            po_d[i] = (i < NUM_BUR) ? rq[NUM_OUT + i] : 1'b0;
         end
      end
   end

   // Output registers.
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         po_q <= po_d;
         oe_q <= oe_d;
      end
   end

   assign pin_o = po_q;
   assign pin_oe_o = oe_q;
   assign ready_o = ready_q;
endmodule : pupo_top
`default_nettype wire

// *** pupo_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches clearing, preload, observe and recovery at the top ports.
module pupo_asserts #(
   parameter int unsigned NUM_OUT = 8,
   parameter int unsigned NUM_BUR = 8,
   parameter int unsigned PWRUP_CYC = 5
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Controls.
   input wire logic preload_i,
   input wire logic observe_i,
   input wire logic bur_sel_i,
   input wire logic [NUM_OUT-1:0] comb_mode_i,
   input wire logic [NUM_OUT-1:0] invert_i,
   // Cell inputs.
   input wire logic [NUM_OUT+NUM_BUR-1:0] func_d_i,
   input wire logic [NUM_OUT-1:0] func_oe_i,
   input wire logic [NUM_OUT+NUM_BUR-1:0] async_rst_i,
   input wire logic [NUM_OUT+NUM_BUR-1:0] async_set_i,
   input wire logic [NUM_OUT-1:0] pin_i,
   // Results.
   input wire logic [NUM_OUT-1:0] pin_o,
   input wire logic [NUM_OUT-1:0] pin_oe_o,
   input wire logic ready_o
);
   localparam int RLO = PWRUP_CYC - 1;
   localparam int RHI = PWRUP_CYC + 1;
   localparam int N = NUM_OUT;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Steps of a preload followed by an observe, and plain running.
   sequence s_load; ready_o && preload_i && !bur_sel_i; endsequence
   sequence s_look; ready_o && observe_i && !preload_i && !bur_sel_i; endsequence
   sequence s_norm; ce_i && ready_o && !preload_i && !observe_i; endsequence
   a_ready_bound: assert property ($fell(sys_rst_i) |-> !ready_o ##[RLO:RHI] ready_o)
      else $error("ready not in time");
   a_ready_hold: assert property (ready_o |=> ready_o)
      else $error("ready dropped");
   a_clear_level: assert property ($fell(sys_rst_i) |-> ((pin_o ^ invert_i) & ~comb_mode_i) == '0)
      else $error("cleared level wrong");
   a_preload_hiz: assert property (ready_o && preload_i |=> pin_oe_o == '0)
      else $error("pins driven in preload");
   a_observe_on: assert property (ready_o && observe_i && !preload_i |=> &pin_oe_o)
      else $error("observe enable missing");
   a_load_show: assert property (s_load ##1 s_look |=> pin_o == (((($past(pin_i, 2)
      | $past(async_set_i[N-1:0], 2)) & ~$past(async_rst_i[N-1:0], 2))) ^ invert_i))
      else $error("observed value wrong");
   a_comb_back: assert property (s_norm |=> ((pin_o ^ invert_i ^ $past(func_d_i[N-1:0]))
      & comb_mode_i) == '0)
      else $error("comb output wrong");
   a_oe_back: assert property (s_norm |=> pin_oe_o == $past(func_oe_i))
      else $error("enable not restored");
endmodule : pupo_asserts
bind pupo_top pupo_asserts #(.NUM_OUT(NUM_OUT), .NUM_BUR(NUM_BUR), .PWRUP_CYC(PWRUP_CYC))
   u_asserts (.*);
`default_nettype wire

// *** pupo_tester.sv ***
`timescale 1ns/1ps
`default_nettype none
// Tester on the pins: drives a level unless the device drives.
module pupo_tester #(
   parameter int unsigned W = 8
) (
   // Clock and tester request.
   input wire logic clk_i,
   input wire logic drive_i,
   input wire logic [W-1:0] val_i,
   // Device pin drive.
   input wire logic [W-1:0] dev_d_i,
   input wire logic [W-1:0] dev_oe_i,
   // Resolved pin level.
   output logic [W-1:0] pin_o
);
   logic [W-1:0] last_q;
   // A pin nobody drives toggles, so stale data is never mistaken for valid.
   assign pin_o = (dev_oe_i & dev_d_i) | (~dev_oe_i & (drive_i ? val_i : ~last_q));
   // Remembers the last pin level.
   always_ff @(posedge clk_i) begin
      last_q <= pin_o;
   end
endmodule : pupo_tester
`default_nettype wire

// *** powerup_reset_preload_observe_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module powerup_reset_preload_observe_test;
   import pupo_pkg::*;
   logic clk_i = 1'b0;
   logic rst = 1'b1, pre = 1'b0, obs = 1'b0, bur = 1'b0, drv = 1'b1, ce = 1'b1, rdy;
   logic [7:0] val = 8'ha7, inv = 8'h0f, foe = 8'hf0, pin, po, poe;
   logic [15:0] fd = 16'h0000, ar = 16'h0000, as = 16'h0000;
   int n_fail = 0, comparisons = 0, cyc = 0;
   // Clock and hang guard.
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 300) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // Device with a short clearing count, and the pin tester.
   pupo_top #(.PWRUP_CYC(5)) DUT (.clk_i(clk_i), .ce_i(ce), .sys_rst_i(rst), .preload_i(pre),
      .observe_i(obs), .bur_sel_i(bur), .comb_mode_i(8'h01), .invert_i(inv), .func_d_i(fd),
      .func_oe_i(foe), .async_rst_i(ar), .async_set_i(as), .pin_i(pin), .pin_o(po),
      .pin_oe_o(poe), .ready_o(rdy));
   pupo_tester u_tester (.clk_i(clk_i), .drive_i(drv), .val_i(val), .dev_d_i(po),
      .dev_oe_i(poe), .pin_o(pin));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic step(input int k);
      repeat (k) @(negedge clk_i);
   endtask : step
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic t_power();
      step(3);
      chk("ready early", 8'h00, {7'h0, rdy});
      step(3);
      chk("ready late", 8'h01, {7'h0, rdy});
      chk("pins after clear", inv, po);
      $display("power-up test done");
   endtask : t_power
   task automatic t_load();
      ar = 16'h0002;
      pre = 1'b1;
      step(1);
      chk("enables in preload", 8'h00, poe);
      step(1);
      pre = 1'b0;
      obs = 1'b1;
      drv = 1'b0;
      ar = 16'h0000;
      step(2);
      chk("observed enables", 8'hff, poe);
      chk("observed outputs", 8'haa, po);
      $display("preload test done");
   endtask : t_load
   task automatic t_bur();
      obs = 1'b0;
      bur = 1'b1;
      pre = 1'b1;
      drv = 1'b1;
      val = 8'h3c;
      as = 16'h0100;
      step(2);
      pre = 1'b0;
      obs = 1'b1;
      drv = 1'b0;
      as = 16'h0000;
      step(2);
      chk("buried observed", 8'h3d, po);
      obs = 1'b0;
      bur = 1'b0;
      $display("buried test done");
   endtask : t_bur
   task automatic t_restore();
      fd = 16'h0001;
      step(3);
      chk("comb output back", 8'h0e, po);
      chk("enables back", foe, poe);
      $display("restore test done");
   endtask : t_restore
   task automatic t_freeze();
      ce = 1'b0;
      fd = 16'h0000;
      step(3);
      chk("frozen outputs", 8'h0e, po);
      ce = 1'b1;
      step(2);
      chk("thawed outputs", 8'h0f, po);
      $display("freeze test done");
   endtask : t_freeze
   // Reset, then the scenarios in order.
   initial begin
      step(10);
      rst = 1'b0;
      t_power();
      t_load();
      t_bur();
      t_restore();
      t_freeze();
      tally_and_finish();
   end
endmodule : powerup_reset_preload_observe_test
`default_nettype wire
